// file: core/baud_gen.sv
`timescale 1ns/1ns
module baud_gen (
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       clock_en,
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [6:0] reload,
   output logic            rollover
);

   // -------------------------------------------------------------------
   // Reload down-counter; one rollover pulse per baud period.
   // -------------------------------------------------------------------
   logic [6:0] count_q;

   // While stopped the counter sits at the reload value, so every phase
   // starts with a full period.
   always_ff @(posedge clock) begin
      if (reset) begin
         count_q  <= 7'h00;
         rollover <= 1'b0;
      end else if (clock_en) begin
         rollover <= 1'b0;
         if (!run || restart) begin
            count_q <= reload;
         end else if (count_q == 7'h00) begin
            count_q  <= reload;
            rollover <= 1'b1;
         end else begin
            count_q <= count_q - 7'h01;
         end
      end
   end

endmodule

// file: core/i2c_master_xfer.sv
// Operation
// - Buffer write sets buffer-full and starts the baud generator for transmission.
// - Data changes after SCL falls; SCL low one period, released one period.
// - Eighth falling edge clears buffer-full and releases SDA for acknowledge.
// - Ninth clock samples SDA: low clears ack status, high sets it.
// - After ninth clock set irq flag, stop generator, hold SCL low.
// - Address byte: seven address bits then direction bit, each on SCL fall.
// - Buffer write during transmission is dropped and sets write collision.
// - Buffer write during reception is dropped and sets write collision.
// - Receive enable starts reception only when idle; otherwise ignored.
// - Reception toggles SCL each rollover and shifts sampled SDA in.
// - Eighth received fall: clear enable, load buffer if not full, set flags, hold SCL, idle.
// - Received byte sets buffer-full; reading the buffer clears it.
// - Ack sequence enable after reception sends an acknowledge bit.
// - Byte completing while buffer-full still set sets receive overflow.
// - Low SDA or SCL at start, or early SCL low: abort, collision, idle.
// - Start with SDA high loads reload field; SCL low meanwhile is collision.
// - SDA sampled low during start count restarts count and drives SDA early.
// - After SDA low, count again ignoring SCL, then drive SCL low.
`timescale 1ns/1ns
`include "i2c_master_regs.svh"
module i2c_master_xfer
   import i2c_master_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       clock_en,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_n,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n
);

   // -------------------------------------------------------------------
   // Declarations.
   // -------------------------------------------------------------------
   state_type  state_q;
   state_type  state_d;
   logic       scl_s;
   logic       sda_s;
   logic       rollover;
   logic       run;
   logic       restart;
   logic [7:0] transfer_buffer_q;
   logic [7:0] shift_register_q;
   logic [2:0] bit_cnt_q;
   logic [7:0] baud_reload_register_q;
   logic       buffer_full_flag_q;
   logic       ack_status_bit_q;
   logic       serial_port_irq_flag_q;
   logic       write_collision_flag_q;
   logic       receive_overflow_flag_q;
   logic       bus_collision_flag_q;
   logic       start_enable_q;
   logic       receive_enable_bit_q;
   logic       ack_sequence_enable_bit_q;
   logic       ack_data_q;
   logic       wr_buf;
   logic       wr_stat;
   logic       wr_ctl;
   logic       wr_baud;
   logic       rd_buf;
   logic       idle;
   logic       eighth;
   logic       tx_take;
   logic       ev_write_collision_flag;
   logic       ev_bcl;
   logic       ev_start_done;
   logic       ev_tx_fall8;
   logic       ev_tx_done;
   logic       ev_rx_done;
   logic       ev_aseq_done;
   logic [7:0] rx_byte;
   logic       sda_want_q;

   // Register decode shared by every strobe.
   function automatic logic hit(input logic [1:0] a, input logic [1:0] off);
      hit = (a == off);
   endfunction

   // -------------------------------------------------------------------
   // Pin sampling and baud generator.
   // -------------------------------------------------------------------
   pin_sync u_sync (
      .clock    (clock),
      .reset    (reset),
      .clock_en (clock_en),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .scl_s    (scl_s),
      .sda_s    (sda_s)
   );

   // The high phases wait for SCL to read high, so a slave that stretches
   // the clock delays the count instead of being overrun.
   always_comb begin
      run = !idle;
      if ((state_q == s_tx_high) || (state_q == s_ack_high) ||
          (state_q == s_rx_high) || (state_q == s_aseq_high)) begin
         run = scl_s;
      end
   end

   baud_gen u_baud (
      .clock    (clock),
      .reset    (reset),
      .clock_en (clock_en),
      .run      (run),
      .restart  (restart),
      .reload   (baud_reload_register_q[6:0]),
      .rollover (rollover)
   );

   // -------------------------------------------------------------------
   // Strobe decode.
   // -------------------------------------------------------------------
   assign wr_buf  = wr && hit(addr, `OFF_TRANSFER_BUFFER);
   assign wr_stat = wr && hit(addr, `OFF_STATUS);
   assign wr_ctl  = wr && hit(addr, `OFF_CONTROL_TWO);
   assign wr_baud = wr && hit(addr, `OFF_BAUD_RELOAD);
   assign rd_buf  = rd && hit(addr, `OFF_TRANSFER_BUFFER);
   assign idle    = (state_q == s_idle);
   assign eighth  = (bit_cnt_q == `LAST_BIT_INDEX);
   assign rx_byte = {shift_register_q[6:0], sda_s};

   // A pending start, reception or acknowledge owns the idle sequencer, so
   // a buffer write then is a collision like one during a transfer.
   assign tx_take = wr_buf && idle && !start_enable_q && !receive_enable_bit_q &&
                    !ack_sequence_enable_bit_q;
   assign ev_write_collision_flag = wr_buf && !tx_take;

   // -------------------------------------------------------------------
   // Sequencer next state and events.
   // -------------------------------------------------------------------
   always_comb begin
      state_d       = state_q;
      restart       = 1'b0;
      ev_bcl        = 1'b0;
      ev_start_done = 1'b0;
      ev_tx_fall8   = 1'b0;
      ev_tx_done    = 1'b0;
      ev_rx_done    = 1'b0;
      ev_aseq_done  = 1'b0;
      unique case (state_q)
         s_idle: begin
            if (start_enable_q) begin
               if (!sda_s || !scl_s) begin
                  ev_bcl = 1'b1;
               end else begin
                  state_d = s_start_hi;
               end
            end else if (tx_take) begin
               state_d = s_tx_low;
            end else if (receive_enable_bit_q) begin
               state_d = s_rx_low;
            end else if (ack_sequence_enable_bit_q) begin
               state_d = s_aseq_low;
            end
         end
         s_start_hi: begin
            if (!scl_s) begin
               ev_bcl  = 1'b1;
               state_d = s_idle;
            end else if (!sda_s) begin
               restart = 1'b1;
               state_d = s_start_lo;
            end else if (rollover) begin
               state_d = s_start_lo;
            end
         end
         s_start_lo: begin
            if (rollover) begin
               ev_start_done = 1'b1;
               state_d       = s_idle;
            end
         end
         s_tx_low: begin
            if (rollover) begin
               state_d = s_tx_high;
            end
         end
         s_tx_high: begin
            if (rollover) begin
               ev_tx_fall8 = eighth;
               state_d     = eighth ? s_ack_low : s_tx_low;
            end
         end
         s_ack_low: begin
            if (rollover) begin
               state_d = s_ack_high;
            end
         end
         s_ack_high: begin
            if (rollover) begin
               ev_tx_done = 1'b1;
               state_d    = s_idle;
            end
         end
         s_rx_low: begin
            if (rollover) begin
               state_d = s_rx_high;
            end
         end
         s_rx_high: begin
            if (rollover) begin
               ev_rx_done = eighth;
               state_d    = eighth ? s_idle : s_rx_low;
            end
         end
         s_aseq_low: begin
            if (rollover) begin
               state_d = s_aseq_high;
            end
         end
         s_aseq_high: begin
            if (rollover) begin
               ev_aseq_done = 1'b1;
               state_d      = s_idle;
            end
         end
         default: begin
            state_d = s_idle;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // Sequencer state, shifter and pin drive.
   // -------------------------------------------------------------------
   // Pins are open drain: an enable of zero pulls the line low and one
   // releases it to the pull-up.
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q          <= s_idle;
         shift_register_q <= `RST_BYTE;
         bit_cnt_q        <= 3'h0;
         scl_oe_n         <= 1'b1;
         sda_want_q       <= 1'b1;
         scl_out          <= 1'b0;
         sda_out          <= 1'b0;
      end else if (clock_en) begin
         state_q <= state_d;
         if (ev_bcl) begin
            scl_oe_n   <= 1'b1;
            sda_want_q <= 1'b1;
         end else if (idle && (state_d == s_start_hi)) begin
            scl_oe_n   <= 1'b1;
            sda_want_q <= 1'b1;
         end else if ((state_q == s_start_hi) && (state_d == s_start_lo)) begin
            sda_want_q <= 1'b0;
         end else if (ev_start_done) begin
            scl_oe_n <= 1'b0;
         end else if (idle && (state_d == s_tx_low)) begin
            shift_register_q <= wdata;
            bit_cnt_q        <= 3'h0;
            scl_oe_n         <= 1'b0;
            sda_want_q       <= wdata[7];
         end else if (idle && (state_d == s_rx_low)) begin
            bit_cnt_q  <= 3'h0;
            scl_oe_n   <= 1'b0;
            sda_want_q <= 1'b1;
         end else if (idle && (state_d == s_aseq_low)) begin
            scl_oe_n   <= 1'b0;
            sda_want_q <= ack_data_q;
         end else if (rollover) begin
            unique case (state_q)
               s_tx_low, s_ack_low, s_rx_low, s_aseq_low: begin
                  scl_oe_n <= 1'b1;
               end
               s_tx_high: begin
                  scl_oe_n  <= 1'b0;
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (eighth) begin
                     sda_want_q <= 1'b1;
                  end else begin
                     shift_register_q <= {shift_register_q[6:0], 1'b0};
                     sda_want_q       <= shift_register_q[6];
                  end
               end
               s_ack_high: begin
                  scl_oe_n <= 1'b0;
               end
               s_rx_high: begin
                  scl_oe_n         <= 1'b0;
                  shift_register_q <= rx_byte;
                  bit_cnt_q        <= bit_cnt_q + 3'h1;
               end
               s_aseq_high: begin
                  scl_oe_n   <= 1'b0;
                  sda_want_q <= 1'b1;
               end
               default: begin
                  scl_oe_n <= scl_oe_n;
               end
            endcase
         end
      end
   end

   // SDA follows its wanted level one cycle late, so data never moves in
   // the cycle in which SCL is pulled low; a collision releases it at once.
   always_ff @(posedge clock) begin
      if (reset) begin
         sda_oe_n <= 1'b1;
      end else if (clock_en) begin
         sda_oe_n <= ev_bcl ? 1'b1 : sda_want_q;
      end
   end

   // -------------------------------------------------------------------
   // Transfer buffer and buffer-full flag.
   // -------------------------------------------------------------------
   // A received byte is not written over an unread one; the old byte is
   // kept and the overflow flag tells software it lost data.
   always_ff @(posedge clock) begin
      if (reset) begin
         transfer_buffer_q  <= `RST_BYTE;
         buffer_full_flag_q <= 1'b0;
      end else if (clock_en) begin
         if (tx_take) begin
            transfer_buffer_q <= wdata;
         end else if (ev_rx_done && !buffer_full_flag_q) begin
            transfer_buffer_q <= rx_byte;
         end
         if (tx_take || ev_rx_done) begin
            buffer_full_flag_q <= 1'b1;
         end else if (ev_tx_fall8 || rd_buf) begin
            buffer_full_flag_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Status flags; software clears all but ack status by writing one, a set wins.
   // -------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         ack_status_bit_q        <= 1'b0;
         serial_port_irq_flag_q  <= 1'b0;
         write_collision_flag_q  <= 1'b0;
         receive_overflow_flag_q <= 1'b0;
         bus_collision_flag_q    <= 1'b0;
      end else if (clock_en) begin
         if (ev_tx_done) begin
            ack_status_bit_q <= sda_s;
         end
         if (ev_tx_done || ev_rx_done || ev_start_done || ev_aseq_done) begin
            serial_port_irq_flag_q <= 1'b1;
         end else if (wr_stat && wdata[`ST_IRQ_FLAG]) begin
            serial_port_irq_flag_q <= 1'b0;
         end
         if (ev_write_collision_flag) begin
            write_collision_flag_q <= 1'b1;
         end else if (wr_stat && wdata[`ST_WRITE_COLLISION]) begin
            write_collision_flag_q <= 1'b0;
         end
         if (ev_rx_done && buffer_full_flag_q) begin
            receive_overflow_flag_q <= 1'b1;
         end else if (wr_stat && wdata[`ST_RECEIVE_OVERFLOW]) begin
            receive_overflow_flag_q <= 1'b0;
         end
         if (ev_bcl) begin
            bus_collision_flag_q <= 1'b1;
         end else if (wr_stat && wdata[`ST_BUS_COLLISION]) begin
            bus_collision_flag_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Control register two and baud reload.
   // -------------------------------------------------------------------
   // Enables are set by software and cleared by hardware on completion.
   always_ff @(posedge clock) begin
      if (reset) begin
         start_enable_q            <= 1'b0;
         receive_enable_bit_q      <= 1'b0;
         ack_sequence_enable_bit_q <= 1'b0;
         ack_data_q                <= 1'b0;
         baud_reload_register_q    <= `RST_BAUD_RELOAD;
      end else if (clock_en) begin
         if (wr_baud) begin
            baud_reload_register_q <= wdata;
         end
         if (wr_ctl) begin
            ack_data_q <= wdata[`CT_ACK_DATA];
         end
         if (ev_start_done || ev_bcl) begin
            start_enable_q <= 1'b0;
         end else if (wr_ctl && wdata[`CT_START_ENABLE] && idle) begin
            start_enable_q <= 1'b1;
         end
         if (ev_rx_done) begin
            receive_enable_bit_q <= 1'b0;
         end else if (wr_ctl && wdata[`CT_RECEIVE_ENABLE] && idle) begin
            receive_enable_bit_q <= 1'b1;
         end
         if (ev_aseq_done) begin
            ack_sequence_enable_bit_q <= 1'b0;
         end else if (wr_ctl && wdata[`CT_ACK_SEQ_ENABLE] && idle) begin
            ack_sequence_enable_bit_q <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Read port, data in the cycle after the strobe.
   // -------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         rdata <= `RST_BYTE;
      end else if (clock_en) begin
         rdata <= `RST_BYTE;
         if (rd) begin
            unique case (addr)
               `OFF_TRANSFER_BUFFER: rdata <= transfer_buffer_q;
               `OFF_STATUS:          rdata <= {1'b0, !idle, bus_collision_flag_q,
                                               receive_overflow_flag_q,
                                               write_collision_flag_q,
                                               serial_port_irq_flag_q,
                                               ack_status_bit_q, buffer_full_flag_q};
               `OFF_CONTROL_TWO:     rdata <= {2'h0, ack_data_q,
                                               ack_sequence_enable_bit_q,
                                               receive_enable_bit_q, 2'h0,
                                               start_enable_q};
               `OFF_BAUD_RELOAD:     rdata <= baud_reload_register_q;
            endcase
         end
      end
   end

endmodule

// file: core/pin_sync.sv
`timescale 1ns/1ns
module pin_sync (
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       clock_en,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            scl_s,
   output logic            sda_s
);

   // -------------------------------------------------------------------
   // Two-stage synchroniser for the bus pins.
   // -------------------------------------------------------------------
   logic [1:0] meta_q;

   // Idle bus level is high, so both stages reset high.
   always_ff @(posedge clock) begin
      if (reset) begin
         meta_q <= 2'h3;
         scl_s  <= 1'b1;
         sda_s  <= 1'b1;
      end else if (clock_en) begin
         meta_q <= {scl_in, sda_in};
         scl_s  <= meta_q[1];
         sda_s  <= meta_q[0];
      end
   end

endmodule

// file: dv/i2c_master_xfer_bench.sv
`timescale 1ns/1ns
// ------------------------------------------------
// Harness.
// ------------------------------------------------
module i2c_master_xfer_bench;
   logic       clock = 1'b0;
   logic       reset = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       scl_oe_n;
   logic       sda_oe_n;
   logic       pull_n;
   logic       jam = 1'b0;
   logic       ack_en = 1'b1;
   logic       rx_mode = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic [8:0] bits = 9'h000;
   logic [7:0] s;
   int         failures = 0;
   int         checks = 0;
   wire        scl_line = scl_oe_n & !jam;
   wire        sda_line = sda_oe_n & pull_n;
   // Free running 250 MHz clock.
   always #2 clock = !clock;
   // Keep the last nine bits seen at each clock rise.
   always @(posedge scl_line) bits <= {bits[7:0], sda_line};
   i2c_master_xfer u_dut (.clock, .reset, .clock_en(1'b1), .addr, .wdata, .wr, .rd, .rdata,
      .scl_in(scl_line), .scl_out(), .scl_oe_n, .sda_in(sda_line), .sda_out(), .sda_oe_n);
   i2c_slave_model u_slave (.clock, .scl(scl_line), .sda(sda_line), .ack_en, .rx_mode,
      .tx_byte(rx_byte), .sda_pull_n(pull_n));
   task automatic end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t: saw %h expected %h", $time, got, exp);
      end
   endtask
   // Strobes stay as set until the next call, so calls chain with no gap.
   task automatic bus(input logic [1:0] a, input logic [7:0] d, input logic w, input logic r);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= r;
      @(posedge clock);
   endtask
   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      bus(a, 8'h00, 1'b0, 1'b1);
      #1 d = rdata;
   endtask
   // Poll status until bit k sets; a hang counts as a failure.
   task automatic wait_bit(input int k);
      for (int i = 0; i < 2000; i++) begin
         rd_reg(2'h1, s);
         if (s[k] === 1'b1) return;
      end
      failures++;
      end_of_test();
   endtask
   // ------------------------------------------------
   // Scenarios.
   // ------------------------------------------------
   task automatic t_start;
      rd_reg(2'h3, s);
      chk(s, 8'h09);
      bus(2'h2, 8'h01, 1'b1, 1'b0);
      wait_bit(2);
      chk({6'h00, scl_oe_n, sda_oe_n}, 8'h00);
      bus(2'h1, 8'h3C, 1'b1, 1'b0);
   endtask
   // A second buffer write and a receive enable arrive mid-byte.
   task automatic t_tx(input logic [7:0] b, input logic a);
      ack_en <= a;
      bus(2'h0, b, 1'b1, 1'b0);
      rd_reg(2'h1, s);
      chk(s & 8'h01, 8'h01);
      bus(2'h0, ~b, 1'b1, 1'b0);
      bus(2'h2, 8'h08, 1'b1, 1'b0);
      wait_bit(2);
      chk(s & 8'h0B, {4'h0, 2'b10, !a, 1'b0});
      chk(bits[8:1], b);
      chk({7'h00, bits[0]}, {7'h00, !a});
      chk({6'h00, scl_oe_n, sda_oe_n}, 8'h01);
      rd_reg(2'h2, s);
      chk(s, 8'h00);
      bus(2'h1, 8'h3C, 1'b1, 1'b0);
   endtask
   task automatic t_rx(input logic [7:0] b, input logic [7:0] st);
      rx_byte <= b;
      rx_mode <= 1'b1;
      bus(2'h2, 8'h08, 1'b1, 1'b0);
      bus(2'h0, 8'hFF, 1'b1, 1'b0);
      wait_bit(2);
      chk(s & 8'h19, st);
      rd_reg(2'h2, s);
      chk(s, 8'h00);
      chk({7'h00, scl_oe_n}, 8'h00);
      rx_mode <= 1'b0;
      bus(2'h1, 8'h3C, 1'b1, 1'b0);
   endtask
   task automatic t_ack;
      bus(2'h2, 8'h10, 1'b1, 1'b0);
      wait_bit(2);
      chk({7'h00, bits[0]}, 8'h00);
      bus(2'h1, 8'h3C, 1'b1, 1'b0);
   endtask
   // Another party holds the clock low when the start begins.
   task automatic t_coll;
      jam <= 1'b1;
      bus(2'h2, 8'h01, 1'b1, 1'b0);
      wait_bit(5);
      chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
      rd_reg(2'h2, s);
      chk(s, 8'h00);
      jam <= 1'b0;
      // A reset clears the collision flag; the clock is then jammed during the start count.
      reset <= 1'b1;
      repeat (3) bus(2'h0, 8'h00, 1'b0, 1'b0);
      reset <= 1'b0;
      bus(2'h2, 8'h01, 1'b1, 1'b0);
      repeat (4) bus(2'h0, 8'h00, 1'b0, 1'b0);
      jam <= 1'b1;
      wait_bit(5);
      chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
      jam <= 1'b0;
   endtask
   initial begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      bus(2'h0, 8'h00, 1'b0, 1'b0);
      rd_reg(2'h1, s);
      chk(s, 8'h00);
      t_start();
      t_tx(8'hA5, 1'b1);
      t_tx(8'h5A, 1'b0);
      t_rx(8'h3C, 8'h09);
      t_ack();
      t_rx(8'hC3, 8'h19);
      rd_reg(2'h0, s);
      chk(s, 8'h3C);
      rd_reg(2'h1, s);
      chk(s & 8'h01, 8'h00);
      t_coll();
      end_of_test();
   end
endmodule

// file: dv/i2c_master_xfer_checker.sv
`timescale 1ns/1ns
// ------------------------------------------------
// Port checks of the transfer block.
// ------------------------------------------------
module i2c_master_xfer_checker (
   input wire logic       clock,
   input wire logic       reset,
   input wire logic [1:0] addr,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       scl_out,
   input wire logic       scl_oe_n,
   input wire logic       sda_out,
   input wire logic       sda_oe_n
);
   // One clock domain, so reset masks every check.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
   property p_drain; scl_out == 1'b0 && sda_out == 1'b0; endproperty
   a_drain: assert property (p_drain) else $error("pin driven high");
   property p_sda_rel; $rose(sda_oe_n) |-> !$past(scl_oe_n); endproperty
   a_sda_rel: assert property (p_sda_rel) else $error("data moved with clock high");
   property p_scl_lo; $fell(scl_oe_n) |=> !scl_oe_n; endproperty
   a_scl_lo: assert property (p_scl_lo) else $error("clock low too short");
   property p_scl_hi; $rose(scl_oe_n) |=> scl_oe_n; endproperty
   a_scl_hi: assert property (p_scl_hi) else $error("clock high too short");
   property p_start; $fell(sda_oe_n) && scl_oe_n |=> scl_oe_n; endproperty
   a_start: assert property (p_start) else $error("clock fell with start");
   // A buffer write is either taken (full) or refused (collision).
   property p_buf;
      wr && addr == 2'h0 ##1 rd && addr == 2'h1 |=> rdata[0] || rdata[3];
   endproperty
   a_buf: assert property (p_buf) else $error("buffer write lost");
   property p_ctl; rd && addr == 2'h2 |=> rdata[7:6] == 2'b00 && rdata[2:1] == 2'b00; endproperty
   a_ctl: assert property (p_ctl) else $error("unused control bits set");
   c_start: cover property ($fell(sda_oe_n) && scl_oe_n);
   c_scl: cover property ($fell(scl_oe_n));
   c_read: cover property (rd && addr == 2'h0);
endmodule
bind i2c_master_xfer i2c_master_xfer_checker u_checker (.clock, .reset, .addr, .wr, .rd,
   .rdata, .scl_out, .scl_oe_n, .sda_out, .sda_oe_n);

// file: dv/i2c_slave_model.sv
`timescale 1ns/1ns
// ------------------------------------------------
// Slave: acks each ninth bit or sends one byte.
// ------------------------------------------------
module i2c_slave_model (
   input wire logic       clock,
   input wire logic       scl,
   input wire logic       sda,
   input wire logic       ack_en,
   input wire logic       rx_mode,
   input wire logic [7:0] tx_byte,
   output logic           sda_pull_n
);
   int   n = 0;
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   logic mode_q = 1'b0;
   // Count clock falls; a start sets -1 so its own fall is not a bit.
   always @(posedge clock) begin
      scl_q <= scl;
      sda_q <= sda;
      mode_q <= rx_mode;
      if (mode_q != rx_mode) n <= 0;
      else if (scl && sda_q && !sda) n <= -1;
      else if (scl_q && !scl) n <= n + 1;
   end
   // Bits change after each fall; released lines read high via pull-up.
   assign sda_pull_n = rx_mode ? (n > 7 || tx_byte[3'd7 - n[2:0]]) : !(ack_en && n % 9 == 8);
endmodule

// file: shared/i2c_master_pkg.sv
package i2c_master_pkg;

   // -------------------------------------------------------------------
   // Sequencer states, one-hot.
   // -------------------------------------------------------------------
   typedef enum logic [10:0] {
      s_idle      = 11'h001,
      s_start_hi  = 11'h002,
      s_start_lo  = 11'h004,
      s_tx_low    = 11'h008,
      s_tx_high   = 11'h010,
      s_ack_low   = 11'h020,
      s_ack_high  = 11'h040,
      s_rx_low    = 11'h080,
      s_rx_high   = 11'h100,
      s_aseq_low  = 11'h200,
      s_aseq_high = 11'h400
   } state_type;

endpackage

// file: shared/i2c_master_regs.svh
`ifndef I2C_MASTER_REGS_SVH
`define I2C_MASTER_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets on the plain register port.
// ----------------------------------------------------------------------
`define OFF_TRANSFER_BUFFER   2'h0
`define OFF_STATUS            2'h1
`define OFF_CONTROL_TWO       2'h2
`define OFF_BAUD_RELOAD       2'h3

// ----------------------------------------------------------------------
// Status register bit positions.
// ----------------------------------------------------------------------
`define ST_BUFFER_FULL        0
`define ST_ACK_STATUS         1
`define ST_IRQ_FLAG           2
`define ST_WRITE_COLLISION    3
`define ST_RECEIVE_OVERFLOW   4
`define ST_BUS_COLLISION      5
`define ST_BUSY               6

// ----------------------------------------------------------------------
// Control register two bit positions.
// ----------------------------------------------------------------------
`define CT_START_ENABLE       0
`define CT_RECEIVE_ENABLE     3
`define CT_ACK_SEQ_ENABLE     4
`define CT_ACK_DATA           5

// ----------------------------------------------------------------------
// Reset values and counts.
// ----------------------------------------------------------------------
`define RST_BAUD_RELOAD       8'h09
`define RST_BYTE              8'h00
`define LAST_BIT_INDEX        3'h7

`endif
